// File: logic/icw_pkg.sv
package icw_pkg;
   // Word indices within the parameter block
   localparam logic [7:0] ICW_W_FIELD_VALID = 8'h35;
   localparam logic [7:0] ICW_W_PIO_IORDY   = 8'h44;
   localparam logic [7:0] ICW_W_RSV_LO_A    = 8'h45;
   localparam logic [7:0] ICW_W_RSV_HI_A    = 8'h4A;
   localparam logic [7:0] ICW_W_QDEPTH      = 8'h4B;
   localparam logic [7:0] ICW_W_RSV_LO_B    = 8'h4C;
   localparam logic [7:0] ICW_W_RSV_HI_B    = 8'h4F;
   localparam logic [7:0] ICW_W_MAJOR       = 8'h50;
   localparam logic [7:0] ICW_W_MINOR       = 8'h51;
   localparam logic [7:0] ICW_W_SUP0        = 8'h52;
   localparam logic [7:0] ICW_W_SUP1        = 8'h53;
   localparam logic [7:0] ICW_W_SUP2        = 8'h54;
   localparam logic [7:0] ICW_W_ENA0        = 8'h55;
   localparam logic [7:0] ICW_W_ENA1        = 8'h56;
   localparam logic [7:0] ICW_W_ENA2        = 8'h57;
   // Field positions
   localparam int ICW_B_FV_64_70  = 1;
   localparam int ICW_B_QUEUED    = 1;
   localparam int ICW_B_PUIS_SUP  = 5;
   localparam int ICW_B_SPINUP    = 6;
   localparam int ICW_B_SETMAX    = 8;
   localparam int ICW_QDEPTH_W    = 5;
   // Word 82 and 85 bit positions
   localparam int ICW_B_SMART     = 0;
   localparam int ICW_B_SECURITY  = 1;
   localparam int ICW_B_REMOVABLE = 2;
   localparam int ICW_B_PWR_MGMT  = 3;
   localparam int ICW_B_WCACHE    = 5;
   localparam int ICW_B_LOOKAHEAD = 6;
   localparam int ICW_B_REL_IRQ   = 7;
   localparam int ICW_B_SVC_IRQ   = 8;
   localparam int ICW_B_DEV_RESET = 9;
   localparam int ICW_B_PROT_AREA = 10;
   localparam int ICW_B_WR_BUF    = 12;
   localparam int ICW_B_RD_BUF    = 13;
   localparam int ICW_B_NOP       = 14;
   // Word 83 and 86 bit positions
   localparam int ICW_B_MICROCODE = 0;
   localparam int ICW_B_CARD_SET  = 2;
   localparam int ICW_B_APM       = 3;
   localparam int ICW_B_MEDIA_ST  = 4;
   // Number of words assembled by the block
   localparam int ICW_LIVE_N      = 11;
   // Validity signature in bits 15:14
   localparam logic [1:0]  ICW_SIG_VALID   = 2'h1;
   localparam logic [15:0] ICW_WORD_ZERO   = 16'h0000;
   localparam logic [15:0] ICW_WORD_NONE   = 16'hFFFF;
   localparam logic [15:0] ICW_MAJOR_MASK  = 16'h003C;
   localparam logic [15:0] ICW_MINOR_LAST  = 16'h0017;
   localparam logic [15:0] ICW_MINOR_RSV   = 16'h0016;
endpackage

// File: logic/icw_identify_words.sv
`timescale 1ns/100ps
module icw_identify_words
   import icw_pkg::*;
#(
   parameter int QDEPTH_MAX = 32
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   // Word read port
   input  wire logic [7:0]  rd_addr_in,
   input  wire logic        rd_strobe_in,
   output logic      [15:0] rd_data_out,
   // Capability straps
   input  wire logic        pio_mode3_in,
   input  wire logic        pio_mode4_in,
   input  wire logic [15:0] pio_t_mode3_ns_in,
   input  wire logic [15:0] pio_t_mode4_ns_in,
   input  wire logic        other_64_70_in,
   input  wire logic [5:0]  queue_depth_in,
   input  wire logic        queue_overlap_only_in,
   input  wire logic [15:0] major_version_in,
   input  wire logic [15:0] minor_version_in,
   input  wire logic [13:0] sup82_in,
   input  wire logic [8:0]  sup83_in,
   input  wire logic [13:0] sup84_in,
   input  wire logic        sup_valid_in,
   input  wire logic        sup84_valid_in,
   input  wire logic        ena_valid_in,
   // Live configuration state
   input  wire logic        en_smart_in,
   input  wire logic        en_security_in,
   input  wire logic        en_wcache_in,
   input  wire logic        en_lookahead_in,
   input  wire logic        en_rel_irq_in,
   input  wire logic        en_svc_irq_in,
   input  wire logic        en_apm_in,
   input  wire logic        en_media_stat_in,
   input  wire logic        en_puis_in,
   input  wire logic        en_setmax_in,
   input  wire logic [13:0] ena87_in
);

   initial begin
      if (QDEPTH_MAX < 1 || QDEPTH_MAX > 32) begin
         $error("QDEPTH_MAX out of range");
      end
      // The field holds depth minus one, so the largest depth must fit its width
      if (QDEPTH_MAX > (1 << ICW_QDEPTH_W)) begin
         $error("QDEPTH_MAX exceeds the queue depth field");
      end
      if (ICW_LIVE_N != 11) begin
         $error("live word count does not match the slot map");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Table bounds: first and last word served here
   localparam int TBL_LO   = int'(ICW_W_FIELD_VALID);
   localparam int TBL_HI   = int'(ICW_W_ENA2);

   // Positions of the live words inside live_w
   localparam int SLOT_W53 = 0;
   localparam int SLOT_W68 = 1;
   localparam int SLOT_W75 = 2;
   localparam int SLOT_W80 = 3;
   localparam int SLOT_W81 = 4;
   localparam int SLOT_W82 = 5;
   localparam int SLOT_W83 = 6;
   localparam int SLOT_W84 = 7;
   localparam int SLOT_W85 = 8;
   localparam int SLOT_W86 = 9;
   localparam int SLOT_W87 = 10;

   // Assembled words, one per index
   logic [15:0] rd_data_ff;
   logic [15:0] nxt_rd_data;
   logic [15:0] w53;
   logic [15:0] w68;
   logic [15:0] w75;
   logic [15:0] w80;
   logic [15:0] w81;
   logic [15:0] w82;
   logic [15:0] w83;
   logic [15:0] w84;
   logic [15:0] w85;
   logic [15:0] w86;
   logic [15:0] w87;
   logic [13:0] w83_body;
   logic        pio_iordy_sup;
   logic [5:0]  qd_clip;
   logic [15:0] live_w   [ICW_LIVE_N];
   logic [15:0] word_tbl [TBL_LO:TBL_HI];

   ////////////////////////////////////////////////////////////////////////////
   // Signature 01 in bits 15:14 marks a group of words as valid
   function automatic logic [15:0] icw_sign(input logic ok, input logic [13:0] body);
      if (ok) begin
         icw_sign = {ICW_SIG_VALID, body};
      end else begin
         icw_sign = {2'h0, body};
      end
   endfunction

   // Slot of a live word in live_w, or -1 for a word that reads zero
   function automatic int icw_slot(input int idx);
      case (idx)
         int'(ICW_W_FIELD_VALID): icw_slot = SLOT_W53;
         int'(ICW_W_PIO_IORDY):   icw_slot = SLOT_W68;
         int'(ICW_W_QDEPTH):      icw_slot = SLOT_W75;
         int'(ICW_W_MAJOR):       icw_slot = SLOT_W80;
         int'(ICW_W_MINOR):       icw_slot = SLOT_W81;
         int'(ICW_W_SUP0):        icw_slot = SLOT_W82;
         int'(ICW_W_SUP1):        icw_slot = SLOT_W83;
         int'(ICW_W_SUP2):        icw_slot = SLOT_W84;
         int'(ICW_W_ENA0):        icw_slot = SLOT_W85;
         int'(ICW_W_ENA1):        icw_slot = SLOT_W86;
         int'(ICW_W_ENA2):        icw_slot = SLOT_W87;
         default:                 icw_slot = -1;
      endcase
   endfunction

   function automatic logic icw_is_reserved(input int idx);
      icw_is_reserved = (idx >= int'(ICW_W_RSV_LO_A) && idx <= int'(ICW_W_RSV_HI_A)) ||
                        (idx >= int'(ICW_W_RSV_LO_B) && idx <= int'(ICW_W_RSV_HI_B));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   assign pio_iordy_sup = pio_mode3_in | pio_mode4_in;

   // Word 53 only partly owned here; other bits stay zero
   always_comb begin
      w53 = ICW_WORD_ZERO;
      w53[ICW_B_FV_64_70] = pio_iordy_sup | other_64_70_in;
   end

   // Fastest supported mode wins
   always_comb begin
      if (pio_mode4_in) begin
         w68 = pio_t_mode4_ns_in;
      end else if (pio_mode3_in) begin
         w68 = pio_t_mode3_ns_in;
      end else begin
         w68 = ICW_WORD_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Depth above what the logic serves is clipped so the field stays legal
   always_comb begin
      if (queue_depth_in > 6'(QDEPTH_MAX)) begin
         qd_clip = 6'(QDEPTH_MAX);
      end else begin
         qd_clip = queue_depth_in;
      end
   end

   // Zero for no queueing, overlap only, or no depth given
   always_comb begin
      w75 = ICW_WORD_ZERO;
      if (sup83_in[ICW_B_QUEUED] && !queue_overlap_only_in && qd_clip != 6'h00) begin
         w75[ICW_QDEPTH_W-1:0] = 5'(qd_clip - 6'h01);
      end
   end

   // Values other than the two no-claim codes are bit significant
   always_comb begin
      if (major_version_in == ICW_WORD_ZERO || major_version_in == ICW_WORD_NONE) begin
         w80 = major_version_in;
      end else begin
         w80 = major_version_in & ICW_MAJOR_MASK;
      end
   end

   // Illegal codes collapse to "not reported" rather than a reserved value
   always_comb begin
      if (minor_version_in == ICW_WORD_NONE) begin
         w81 = ICW_WORD_NONE;
      end else if (minor_version_in > ICW_MINOR_LAST || minor_version_in == ICW_MINOR_RSV) begin
         w81 = ICW_WORD_ZERO;
      end else begin
         w81 = minor_version_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Supported feature word; bits 4, 11 and 15 stay zero
   always_comb begin
      w82 = ICW_WORD_ZERO;
      // Optional feature sets
      w82[ICW_B_SMART]     = sup82_in[0];
      w82[ICW_B_SECURITY]  = sup82_in[1];
      w82[ICW_B_REMOVABLE] = sup82_in[2];
      w82[ICW_B_PWR_MGMT]  = sup82_in[3];

      // Cache, interrupts, reset and protected area
      w82[ICW_B_WCACHE]    = sup82_in[4];
      w82[ICW_B_LOOKAHEAD] = sup82_in[5];
      w82[ICW_B_REL_IRQ]   = sup82_in[6];
      w82[ICW_B_SVC_IRQ]   = sup82_in[7];
      w82[ICW_B_DEV_RESET] = sup82_in[8];
      w82[ICW_B_PROT_AREA] = sup82_in[9];

      // Buffer and no-operation commands
      w82[ICW_B_WR_BUF]    = sup82_in[10];
      w82[ICW_B_RD_BUF]    = sup82_in[11];
      w82[ICW_B_NOP]       = sup82_in[12];
   end

   always_comb begin
      w83_body = 14'h0000;

      w83_body[ICW_B_MICROCODE] = sup83_in[ICW_B_MICROCODE];
      w83_body[ICW_B_QUEUED]    = sup83_in[ICW_B_QUEUED];
      w83_body[ICW_B_CARD_SET]  = sup83_in[ICW_B_CARD_SET];
      w83_body[ICW_B_APM]       = sup83_in[ICW_B_APM];
      w83_body[ICW_B_MEDIA_ST]  = sup83_in[ICW_B_MEDIA_ST];
      w83_body[ICW_B_PUIS_SUP]  = sup83_in[ICW_B_PUIS_SUP];

      // Spin-up need only means something with standby power-up present
      w83_body[ICW_B_SPINUP]    = sup83_in[ICW_B_SPINUP] & sup83_in[ICW_B_PUIS_SUP];
      w83_body[ICW_B_SETMAX]    = sup83_in[ICW_B_SETMAX];
   end

   assign w83 = icw_sign(sup_valid_in, w83_body);

   // Word 84 carries its own signature
   assign w84 = icw_sign(sup84_valid_in, sup84_in);

   ////////////////////////////////////////////////////////////////////////////
   // Enabled feature words follow live state so the next read sees it
   always_comb begin
      w85 = ICW_WORD_ZERO;
      // Enables set by their commands
      w85[ICW_B_SMART]     = en_smart_in;
      w85[ICW_B_SECURITY]  = en_security_in;
      w85[ICW_B_WCACHE]    = en_wcache_in;
      w85[ICW_B_LOOKAHEAD] = en_lookahead_in;
      w85[ICW_B_REL_IRQ]   = en_rel_irq_in;
      w85[ICW_B_SVC_IRQ]   = en_svc_irq_in;

      // Support bits repeated from word 82
      w85[ICW_B_REMOVABLE] = w82[ICW_B_REMOVABLE];
      w85[ICW_B_PWR_MGMT]  = w82[ICW_B_PWR_MGMT];
      w85[ICW_B_DEV_RESET] = w82[ICW_B_DEV_RESET];
      w85[ICW_B_PROT_AREA] = w82[ICW_B_PROT_AREA];
      w85[ICW_B_WR_BUF]    = w82[ICW_B_WR_BUF];
      w85[ICW_B_RD_BUF]    = w82[ICW_B_RD_BUF];
      w85[ICW_B_NOP]       = w82[ICW_B_NOP];
   end

   always_comb begin
      w86 = ICW_WORD_ZERO;
      // Support bits repeated from word 83
      w86[ICW_B_MICROCODE] = w83[ICW_B_MICROCODE];
      w86[ICW_B_QUEUED]    = w83[ICW_B_QUEUED];
      w86[ICW_B_CARD_SET]  = w83[ICW_B_CARD_SET];

      // Enables turned on by set-features
      w86[ICW_B_APM]       = en_apm_in;
      w86[ICW_B_MEDIA_ST]  = en_media_stat_in;
      w86[ICW_B_PUIS_SUP]  = en_puis_in;

      w86[ICW_B_SPINUP]    = w83[ICW_B_SPINUP];
      w86[ICW_B_SETMAX]    = en_setmax_in;
   end

   // Signature here vouches for words 85 to 87 together
   assign w87 = icw_sign(ena_valid_in, ena87_in);

   ////////////////////////////////////////////////////////////////////////////
   // Live words in slot order
   assign live_w[SLOT_W53] = w53;
   assign live_w[SLOT_W68] = w68;
   assign live_w[SLOT_W75] = w75;
   assign live_w[SLOT_W80] = w80;
   assign live_w[SLOT_W81] = w81;
   assign live_w[SLOT_W82] = w82;
   assign live_w[SLOT_W83] = w83;
   assign live_w[SLOT_W84] = w84;
   assign live_w[SLOT_W85] = w85;
   assign live_w[SLOT_W86] = w86;
   assign live_w[SLOT_W87] = w87;

   // Unmapped and reserved words are tied to zero in the table itself
   for (genvar gi = TBL_LO; gi <= TBL_HI; gi++) begin : g_word
      if (icw_is_reserved(gi) || icw_slot(gi) < 0) begin : g_zero
         assign word_tbl[gi] = ICW_WORD_ZERO;
      end else begin : g_live
         assign word_tbl[gi] = live_w[icw_slot(gi)];
      end
   end

   // Words outside the table read zero
   always_comb begin
      nxt_rd_data = ICW_WORD_ZERO;
      if (rd_addr_in >= ICW_W_FIELD_VALID && rd_addr_in <= ICW_W_ENA2) begin
         nxt_rd_data = word_tbl[int'(rd_addr_in)];
      end
   end

   // Data held only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data_ff <= ICW_WORD_ZERO;
      end else if (rd_strobe_in) begin
         rd_data_ff <= nxt_rd_data;
      end else begin
         rd_data_ff <= ICW_WORD_ZERO;
      end
   end

   assign rd_data_out = rd_data_ff;

endmodule

// File: testbench/icw_identify_words_chk_asserts.sv
`timescale 1ns/100ps
module icw_identify_words_chk
   import icw_pkg::*;
(
   // Clock and read port
   input wire logic        clk_in,
   input wire logic        reset_n_in,
   input wire logic [7:0]  rd_addr_in,
   input wire logic        rd_strobe_in,
   input wire logic [15:0] rd_data_out,
   // Straps and live state
   input wire logic        pio_mode3_in,
   input wire logic        pio_mode4_in,
   input wire logic [15:0] pio_t_mode4_ns_in,
   input wire logic [8:0]  sup83_in,
   input wire logic        sup_valid_in,
   input wire logic        en_wcache_in
);
   wire logic       s = rd_strobe_in;
   wire logic [7:0] a = rd_addr_in;
   wire logic [15:0] d = rd_data_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   chk_idle_zero: assert property (!s |=> d == 16'h0000) else $error("data not idle");
   chk_w53_valid: assert property (s && a == ICW_W_FIELD_VALID && (pio_mode3_in || pio_mode4_in)
      |=> d[1]) else $error("w53 bit 1 low");
   chk_w68_fast: assert property (s && a == ICW_W_PIO_IORDY && pio_mode4_in
      |=> d == $past(pio_t_mode4_ns_in)) else $error("w68 not mode 4 time");
   chk_w68_none: assert property (s && a == ICW_W_PIO_IORDY && !pio_mode3_in && !pio_mode4_in
      |=> d == 16'h0000) else $error("w68 not zero");
   chk_rsv_zero: assert property (s && (a inside {[ICW_W_RSV_LO_A:ICW_W_RSV_HI_A],
      [ICW_W_RSV_LO_B:ICW_W_RSV_HI_B]}) |=> d == 16'h0000) else $error("reserved not zero");
   chk_qd_unsup: assert property (s && a == ICW_W_QDEPTH && !sup83_in[1]
      |=> d == 16'h0000) else $error("queue depth not zero");
   chk_w82_fixed: assert property (s && a == ICW_W_SUP0
      |=> !d[4] && !d[11] && !d[15]) else $error("w82 fixed bits set");
   chk_sig_w83: assert property (s && a == ICW_W_SUP1
      |=> d[15:14] == ($past(sup_valid_in) ? ICW_SIG_VALID : 2'h0)) else $error("w83 signature");
   chk_wcache_live: assert property (s && a == ICW_W_ENA0
      |=> d[5] == $past(en_wcache_in)) else $error("w85 cache bit stale");
   cover property (s && a == ICW_W_ENA0 && !en_wcache_in);
   cover property (s && a == ICW_W_QDEPTH && !sup83_in[1]);
   cover property (s && a == ICW_W_PIO_IORDY && !pio_mode4_in);
endmodule
bind icw_identify_words icw_identify_words_chk i_icw_identify_words_chk (.clk_in, .reset_n_in,
   .rd_addr_in, .rd_strobe_in, .rd_data_out, .pio_mode3_in, .pio_mode4_in, .pio_t_mode4_ns_in,
   .sup83_in, .sup_valid_in, .en_wcache_in);

// File: testbench/icw_host_model.sv
`timescale 1ns/100ps
module icw_host_model (
   // Clock
   input  wire logic        clk_in,
   // Read port toward the block
   input  wire logic [15:0] rd_data_in,
   output logic      [7:0]  rd_addr_out,
   output logic             rd_strobe_out
);
   initial begin
      rd_addr_out = 8'hFF;
      rd_strobe_out = 1'b0;
   end
   task automatic read(input logic [7:0] addr, output logic [15:0] data);
      @(posedge clk_in);
      rd_strobe_out <= 1'b1;
      rd_addr_out <= addr;
      @(posedge clk_in);
      rd_strobe_out <= 1'b0;
      // Idle address is inverted so a stale match cannot hide a late capture
      rd_addr_out <= ~addr;
      // Answer stands for the cycle after the strobe; take it at that cycle's closing edge
      @(posedge clk_in);
      data = rd_data_in;
   endtask
endmodule

// File: testbench/icw_identify_words_tb_top.sv
`timescale 1ns/100ps
module icw_identify_words_tb_top;
   import icw_pkg::*;
   logic clk_in = 0, reset_n_in = 0, pio_mode3_in = 1, pio_mode4_in = 1, other_64_70_in = 0;
   logic queue_overlap_only_in = 0, sup_valid_in = 1, sup84_valid_in = 1, ena_valid_in = 1;
   logic en_smart_in = 1, en_security_in = 1, en_wcache_in = 1, en_lookahead_in = 1;
   logic en_rel_irq_in = 1, en_svc_irq_in = 1, en_apm_in = 1, en_media_stat_in = 1;
   logic en_puis_in = 1, en_setmax_in = 1, rd_strobe_in;
   logic [15:0] pio_t_mode3_ns_in = 16'h00B4, pio_t_mode4_ns_in = 16'h0078, rd_data_out;
   logic [15:0] major_version_in = 16'h001E, minor_version_in = 16'h0017;
   logic [13:0] sup82_in = 14'h3FFF, sup84_in = 14'h0ABC, ena87_in = 14'h1234;
   logic [8:0]  sup83_in = 9'h1FF;
   logic [5:0]  queue_depth_in = 6'h20;
   logic [7:0]  rd_addr_in;
   int error_cnt = 0, checks = 0, cyc = 0;
   logic [23:0] rows [13] = '{24'h35_0002, 24'h44_0078,
      24'h45_0000, 24'h4F_0000, 24'h4B_001F,
      24'h50_001C, 24'h51_0017, 24'h52_77EF,
      24'h53_417F, 24'h54_4ABC, 24'h55_77EF,
      24'h56_017F, 24'h57_5234};
   always #4 clk_in = ~clk_in;
   icw_identify_words #(.QDEPTH_MAX(32)) i_icw_identify_words (.*);
   icw_host_model i_icw_host_model (.clk_in, .rd_data_in(rd_data_out),
      .rd_addr_out(rd_addr_in), .rd_strobe_out(rd_strobe_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      i_icw_host_model.read(a, d);
      chk(d, e);
   endtask
   task automatic end_sim();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Generous ceiling: the whole sequence needs well under 200 cycles
   always @(posedge clk_in) begin
      cyc++;
      if (cyc > 2000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      repeat (4) @(posedge clk_in);
      chk(rd_data_out, 16'h0000);
      reset_n_in <= 1;
      foreach (rows[i]) rd(rows[i][23:16], rows[i][15:0]);
      @(posedge clk_in) en_wcache_in <= 0;
      sup_valid_in <= 0;
      rd(ICW_W_ENA0, 16'h77CF);
      rd(ICW_W_SUP1, 16'h017F);
      @(posedge clk_in) queue_overlap_only_in <= 1;
      rd(ICW_W_QDEPTH, 16'h0000);
      @(posedge clk_in) queue_overlap_only_in <= 0;
      sup83_in <= 9'h1FD;
      rd(ICW_W_QDEPTH, 16'h0000);
      @(posedge clk_in) sup83_in <= 9'h1FF;
      queue_depth_in <= 6'h01;
      rd(ICW_W_QDEPTH, 16'h0000);
      @(posedge clk_in) pio_mode4_in <= 0;
      rd(ICW_W_PIO_IORDY, 16'h00B4);
      @(posedge clk_in) pio_mode3_in <= 0;
      other_64_70_in <= 1;
      rd(ICW_W_PIO_IORDY, 16'h0000);
      @(posedge clk_in) minor_version_in <= 16'h0016;
      major_version_in <= 16'hFFFF;
      rd(ICW_W_MINOR, 16'h0000);
      rd(ICW_W_MAJOR, 16'hFFFF);
      @(posedge clk_in) minor_version_in <= 16'h0018;
      rd(ICW_W_MINOR, 16'h0000);
      end_sim();
   end
endmodule
